// >>> rtl/lesl_defs.svh
// Constants for the load, extend and shift-left execute slice.
// Assumes inclusion by bare name from the package and the execute module.
`ifndef LESL_DEFS_SVH
`define LESL_DEFS_SVH

// Opcode values of the upper instruction bits.
`define LESL_OP7_LDB_U_REG  7'h2E
`define LESL_OP7_LDH_U_REG  7'h2D
`define LESL_OP7_LDB_S_REG  7'h2B
`define LESL_OP7_LDH_S_REG  7'h2F
`define LESL_OP5_LDH_U_IMM  5'h11
`define LESL_OP5_SHL_IMM    5'h00
`define LESL_OP10_SHL_REG   10'h102

// Field positions inside the 16-bit instruction.
`define LESL_RT_LSB   0
`define LESL_RN_LSB   3
`define LESL_RM_LSB   6
`define LESL_FIVE_BIT_IMMEDIATE_LSB 6

// Reset values.
`define LESL_REG_RST  32'h0000_0000
`define LESL_FLAG_RST 4'h0

`endif

// >>> rtl/lesl_pkg.sv
// Types for the load, extend and shift-left execute slice.
// Assumes the constants header sits beside it.
`include "lesl_defs.svh"

package lesl_pkg;

  // One-hot control states.
  typedef enum logic [1:0] {
    LESL_ST_IDLE = 2'b01,
    LESL_ST_LOAD = 2'b10
  } lesl_state_e;

  // One-hot kinds of pending load.
  typedef enum logic [3:0] {
    LESL_LD_BYTE_U = 4'b0001,
    LESL_LD_BYTE_S = 4'b0010,
    LESL_LD_HALF_U = 4'b0100,
    LESL_LD_HALF_S = 4'b1000
  } lesl_load_e;

  // Whole state of the execute slice.
  typedef struct packed {
    lesl_state_e      state;
    lesl_load_e       load;
    logic [7:0][31:0] regs;
    logic             flag_n;
    logic             flag_z;
    logic             flag_c;
    logic             flag_v;
    logic             busy;
    logic             mem_req;
    logic             mem_half;
    logic [31:0]      mem_addr;
    logic [2:0]       tgt;
    logic             wb_valid;
    logic [2:0]       wb_idx;
    logic [31:0]      wb_data;
    logic             done;
    logic             fault;
    logic             illegal;
  } lesl_state_s;

endpackage : lesl_pkg

// >>> rtl/lesl_shl.sv
// Combinational logical left shifter with carry out.
// Assumes the caller registers its outputs.
`timescale 1ns/100ps
`default_nettype none

module lesl_shl (
  // Operand and amount.
  input  wire logic [31:0] value,
  input  wire logic [7:0]  amount,
  input  wire logic        carry_in,
  // Result.
  output logic      [31:0] result,
  output logic             carry
);

  logic [32:0] ext;

  // Zeros enter at the low end; amounts past 32 flush everything.
  always_comb begin
    ext = {1'b0, value} << amount[5:0];
    if (amount == 8'h00) begin
      result = value;
      carry  = carry_in;
    end else if (amount <= 8'h20) begin
      result = ext[31:0];
      carry  = ext[32];
    end else begin
      result = 32'h0000_0000;
      carry  = 1'b0;
    end
  end

endmodule : lesl_shl

`default_nettype wire

// >>> rtl/lesl_exec.sv
// Decode and execute for register-offset byte loads, halfword loads, signed loads
// and logical left shifts, with a small low register file and condition flags.
// Assumes the core holds instr_valid until busy is low and answers mem_req with mem_ack.
//
// Functional notes
// - Register-offset loads address base plus unshifted offset and never write the base back.
// - Signed byte loads sign-extend from bit 7, unsigned byte loads zero-fill.
// - The immediate halfword load adds the five-bit field times two to the base.
// - Unsigned halfword loads clear bits 31 to 16 of the target.
// - The signed halfword load copies bit 15 into bits 31 to 16.
// - The immediate halfword load only adds and leaves the base untouched.
// - Register-offset loads take target 2:0, base 5:3, offset 8:6 and their upper opcodes.
// - An immediate left shift with a zero shift field executes as a flag-setting move.
// - The immediate shift amount is bits 10:6, source 5:3 and destination 2:0.
// - Both left shifts move toward the top, fill zeros and write the destination.
// - Left shifts set N from bit 31, Z on zero, C from the carry and keep V.
// - The register shift takes its amount from the low byte of the second register.
// - Bits above the low byte of the amount register are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "lesl_defs.svh"

module lesl_exec (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Instruction issue.
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  // Register and flag preload from the core.
  input  wire logic        init_we,
  input  wire logic [2:0]  init_idx,
  input  wire logic [31:0] init_data,
  input  wire logic        init_flags_we,
  input  wire logic [3:0]  init_flags,
  // Data memory load port.
  output logic             mem_req_r,
  output logic             mem_half_r,
  output logic      [31:0] mem_addr_r,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Results.
  output logic             busy_r,
  output logic             done_r,
  output logic             fault_r,
  output logic             illegal_r,
  output logic             wb_valid_r,
  output logic      [2:0]  wb_idx_r,
  output logic      [31:0] wb_data_r,
  output logic             flag_n_r,
  output logic             flag_z_r,
  output logic             flag_c_r,
  output logic             flag_v_r
);

  lesl_pkg::lesl_state_s q_r;
  lesl_pkg::lesl_state_s q_nxt;

  // Picks a three-bit register field out of the instruction.
  function automatic logic [2:0] reg_field(input logic [15:0] ins, input int lsb);
    return ins[lsb +: 3];
  endfunction : reg_field

  // Widens loaded data as the pending load kind asks.
  function automatic logic [31:0] extend(input lesl_pkg::lesl_load_e kind,
                                         input logic [31:0] d);
    unique case (kind)
      lesl_pkg::LESL_LD_BYTE_U: return {24'h00_0000, d[7:0]};
      lesl_pkg::LESL_LD_BYTE_S: return {{24{d[7]}}, d[7:0]};
      lesl_pkg::LESL_LD_HALF_U: return {16'h0000, d[15:0]};
      lesl_pkg::LESL_LD_HALF_S: return {{16{d[15]}}, d[15:0]};
    endcase
  endfunction : extend

  logic [2:0]  f_rt;
  logic [2:0]  f_rn;
  logic [2:0]  f_rm;
  logic [4:0]  f_five_bit_immediate;
  logic        dec_ldb_u;
  logic        dec_ldh_u_reg;
  logic        dec_ldb_s;
  logic        dec_ldh_s;
  logic        dec_ldh_imm;
  logic        dec_ld_any;
  logic        dec_ld_half;
  logic        dec_shl_imm;
  logic        dec_mov;
  logic        dec_shl_reg;
  logic        accept;
  logic [31:0] ld_addr;
  logic [31:0] sh_value;
  logic [7:0]  sh_amount;
  logic [31:0] sh_result;
  logic        sh_carry;

  // Field extraction and opcode decode.
  always_comb begin
    f_rt          = reg_field(instr, `LESL_RT_LSB);
    f_rn          = reg_field(instr, `LESL_RN_LSB);
    f_rm          = reg_field(instr, `LESL_RM_LSB);
    f_five_bit_immediate        = instr[`LESL_FIVE_BIT_IMMEDIATE_LSB +: 5];
    dec_ldb_u     = instr[15:9] == `LESL_OP7_LDB_U_REG;
    dec_ldh_u_reg = instr[15:9] == `LESL_OP7_LDH_U_REG;
    dec_ldb_s     = instr[15:9] == `LESL_OP7_LDB_S_REG;
    dec_ldh_s     = instr[15:9] == `LESL_OP7_LDH_S_REG;
    dec_ldh_imm   = instr[15:11] == `LESL_OP5_LDH_U_IMM;
    dec_ld_any    = dec_ldb_u | dec_ldh_u_reg | dec_ldb_s | dec_ldh_s | dec_ldh_imm;
    dec_ld_half   = dec_ldh_u_reg | dec_ldh_s | dec_ldh_imm;
    dec_shl_imm   = (instr[15:11] == `LESL_OP5_SHL_IMM) && (f_five_bit_immediate != 5'h00);
    dec_mov       = (instr[15:11] == `LESL_OP5_SHL_IMM) && (f_five_bit_immediate == 5'h00);
    dec_shl_reg   = instr[15:6] == `LESL_OP10_SHL_REG;
    accept        = instr_valid && (q_r.state == lesl_pkg::LESL_ST_IDLE);
  end

  // Address adder; the register form adds the offset unshifted, the immediate form adds
  // the field times two, and neither ever subtracts.
  always_comb begin
    if (dec_ldh_imm) begin
      ld_addr = q_r.regs[f_rn] + {26'h000_0000, f_five_bit_immediate, 1'b0};
    end else begin
      ld_addr = q_r.regs[f_rn] + q_r.regs[f_rm];
    end
  end

  // Shifter operands for the immediate and register forms.
  always_comb begin
    if (dec_shl_reg) begin
      sh_value  = q_r.regs[f_rt];
      sh_amount = q_r.regs[f_rn][7:0];
    end else begin
      sh_value  = q_r.regs[f_rn];
      sh_amount = {3'h0, f_five_bit_immediate};
    end
  end

  lesl_shl u_shl (
    .value    (sh_value),
    .amount   (sh_amount),
    .carry_in (q_r.flag_c),
    .result   (sh_result),
    .carry    (sh_carry)
  );

  // Next-state logic; a write-back from this slice wins over a preload to the same register.
  always_comb begin
    q_nxt          = q_r;
    q_nxt.wb_valid = 1'b0;
    q_nxt.done     = 1'b0;
    q_nxt.fault    = 1'b0;
    q_nxt.illegal  = 1'b0;
    if (init_we) begin
      q_nxt.regs[init_idx] = init_data;
    end
    if (init_flags_we) begin
      {q_nxt.flag_n, q_nxt.flag_z, q_nxt.flag_c, q_nxt.flag_v} = init_flags;
    end
    unique case (q_r.state)
      lesl_pkg::LESL_ST_IDLE: begin
        if (instr_valid) begin
          q_nxt.done = 1'b1;
          if (dec_ld_any) begin
            if (dec_ld_half && ld_addr[0]) begin
              q_nxt.fault = 1'b1;
            end else begin
              q_nxt.done     = 1'b0;
              q_nxt.mem_req  = 1'b1;
              q_nxt.mem_addr = ld_addr;
              q_nxt.mem_half = dec_ld_half;
              q_nxt.tgt      = f_rt;
              q_nxt.busy     = 1'b1;
              q_nxt.state    = lesl_pkg::LESL_ST_LOAD;
              if (dec_ldb_s) begin
                q_nxt.load = lesl_pkg::LESL_LD_BYTE_S;
              end else if (dec_ldh_s) begin
                q_nxt.load = lesl_pkg::LESL_LD_HALF_S;
              end else if (dec_ld_half) begin
                q_nxt.load = lesl_pkg::LESL_LD_HALF_U;
              end else begin
                q_nxt.load = lesl_pkg::LESL_LD_BYTE_U;
              end
            end
          end else if (dec_shl_imm || dec_shl_reg) begin
            q_nxt.regs[f_rt] = sh_result;
            q_nxt.wb_valid   = 1'b1;
            q_nxt.wb_idx     = f_rt;
            q_nxt.wb_data    = sh_result;
            q_nxt.flag_n     = sh_result[31];
            q_nxt.flag_z     = sh_result == 32'h0000_0000;
            q_nxt.flag_c     = sh_carry;
          end else if (dec_mov) begin
            q_nxt.regs[f_rt] = q_r.regs[f_rn];
            q_nxt.wb_valid   = 1'b1;
            q_nxt.wb_idx     = f_rt;
            q_nxt.wb_data    = q_r.regs[f_rn];
            q_nxt.flag_n     = q_r.regs[f_rn][31];
            q_nxt.flag_z     = q_r.regs[f_rn] == 32'h0000_0000;
          end else begin
            q_nxt.illegal = 1'b1;
          end
        end
      end
      lesl_pkg::LESL_ST_LOAD: begin
        if (mem_ack) begin
          q_nxt.regs[q_r.tgt] = extend(q_r.load, mem_rdata);
          q_nxt.wb_valid      = 1'b1;
          q_nxt.wb_idx        = q_r.tgt;
          q_nxt.wb_data       = extend(q_r.load, mem_rdata);
          q_nxt.mem_req       = 1'b0;
          q_nxt.busy          = 1'b0;
          q_nxt.done          = 1'b1;
          q_nxt.state         = lesl_pkg::LESL_ST_IDLE;
        end
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      q_r          <= '0;
      q_r.state    <= lesl_pkg::LESL_ST_IDLE;
      q_r.load     <= lesl_pkg::LESL_LD_BYTE_U;
      q_r.regs     <= {8{`LESL_REG_RST}};
      {q_r.flag_n, q_r.flag_z, q_r.flag_c, q_r.flag_v} <= `LESL_FLAG_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register.
  assign mem_req_r  = q_r.mem_req;
  assign mem_half_r = q_r.mem_half;
  assign mem_addr_r = q_r.mem_addr;
  assign busy_r     = q_r.busy;
  assign done_r     = q_r.done;
  assign fault_r    = q_r.fault;
  assign illegal_r  = q_r.illegal;
  assign wb_valid_r = q_r.wb_valid;
  assign wb_idx_r   = q_r.wb_idx;
  assign wb_data_r  = q_r.wb_data;
  assign flag_n_r   = q_r.flag_n;
  assign flag_z_r   = q_r.flag_z;
  assign flag_c_r   = q_r.flag_c;
  assign flag_v_r   = q_r.flag_v;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // A register-offset load issues base plus offset.
  property p_addr_reg;
    accept && dec_ld_any && !dec_ldh_imm && !(dec_ld_half && ld_addr[0]) |=>
      mem_req_r && mem_addr_r == $past(q_r.regs[f_rn]) + $past(q_r.regs[f_rm]);
  endproperty
  a_addr_reg: assert property (p_addr_reg) else $error("register load address wrong");

  // The immediate halfword load issues base plus twice the field.
  property p_addr_imm;
    accept && dec_ldh_imm && !ld_addr[0] |=>
      mem_addr_r == $past(q_r.regs[f_rn]) + {26'h000_0000, $past(f_five_bit_immediate), 1'b0};
  endproperty
  a_addr_imm: assert property (p_addr_imm) else $error("immediate load address wrong");

  // A waiting request holds its address until acknowledged.
  sequence s_wait;
    mem_req_r && !mem_ack;
  endsequence
  sequence s_finish;
    mem_req_r && mem_ack;
  endsequence
  property p_req_holds;
    s_wait |=> mem_req_r && $stable(mem_addr_r) && $stable(q_r.regs);
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("load request dropped");

  // A finished load writes only its target, widened by kind.
  property p_load_wb;
    s_finish |=> wb_valid_r && !mem_req_r && wb_idx_r == $past(q_r.tgt) &&
      wb_data_r == extend($past(q_r.load), $past(mem_rdata));
  endproperty
  a_load_wb: assert property (p_load_wb) else $error("load write-back wrong");

  // Signed byte load replicates bit 7.
  property p_byte_sign;
    s_finish and (q_r.load == lesl_pkg::LESL_LD_BYTE_S) |=>
      wb_data_r == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])};
  endproperty
  a_byte_sign: assert property (p_byte_sign) else $error("byte sign extension wrong");

  // Unsigned halfword load clears the upper half.
  property p_half_zero;
    s_finish and (q_r.load == lesl_pkg::LESL_LD_HALF_U) |=>
      wb_data_r[31:16] == 16'h0000 && wb_data_r[15:0] == $past(mem_rdata[15:0]);
  endproperty
  a_half_zero: assert property (p_half_zero) else $error("half zero extension wrong");

  // Signed halfword load replicates bit 15.
  property p_half_sign;
    s_finish and (q_r.load == lesl_pkg::LESL_LD_HALF_S) |=>
      wb_data_r[31:16] == {16{wb_data_r[15]}};
  endproperty
  a_half_sign: assert property (p_half_sign) else $error("half sign extension wrong");

  // An odd halfword address faults without any access.
  property p_fault;
    accept && dec_ld_half && ld_addr[0] |=> fault_r && !mem_req_r && !busy_r;
  endproperty
  a_fault: assert property (p_fault) else $error("odd halfword not faulted");

  // A zero shift field moves the source and keeps carry.
  property p_mov;
    accept && dec_mov |=> wb_data_r == $past(q_r.regs[f_rn]) && $stable(flag_c_r);
  endproperty
  a_mov: assert property (p_mov) else $error("zero-field shift not a move");

  // Immediate shift result and flags.
  property p_shl_imm;
    accept && dec_shl_imm |=> wb_data_r == ($past(q_r.regs[f_rn]) << $past(f_five_bit_immediate)) &&
      flag_n_r == wb_data_r[31] && flag_z_r == (wb_data_r == 32'h0000_0000) && $stable(flag_v_r);
  endproperty
  a_shl_imm: assert property (p_shl_imm) else $error("immediate shift wrong");

  // Register shift uses only the low byte; large amounts flush with carry cleared.
  property p_shl_big;
    accept && dec_shl_reg && q_r.regs[f_rn][7:0] > 8'h20 |=> wb_data_r == 32'h0000_0000 &&
      !flag_c_r && flag_z_r;
  endproperty
  a_shl_big: assert property (p_shl_big) else $error("large shift not flushed");

endmodule : lesl_exec

`default_nettype wire

// >>> verif/lesl_mem_model.sv
// Data memory load port model for the execute slice.
// Assumes the bench picks the answer latency per load.
`timescale 1ns/100ps
`default_nettype none

module lesl_mem_model (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Load request from the slice.
  input  wire logic        mem_req_r,
  input  wire logic [31:0] mem_addr_r,
  // Answer latency in cycles.
  input  wire logic [1:0]  lat,
  // Answer to the slice.
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [2:0] cnt;

  // Memory content is a fixed scramble of the byte address.
  function automatic logic [31:0] word(input logic [31:0] a);
    return (a * 32'h9E3779B1) ^ 32'h5A5A0F0F;
  endfunction : word

  // Answers after the latency and toggles the data outside the answer cycle.
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h00000000;
    cnt = 3'h0;
  end
  always @(negedge clock) begin
    if (rst || mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 3'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req_r && cnt >= {1'b0, lat}) begin
      mem_ack <= 1'b1;
      mem_rdata <= word(mem_addr_r);
    end else begin
      cnt <= mem_req_r ? cnt + 3'h1 : 3'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : lesl_mem_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the execute slice against a reference model.
// Assumes the memory model answers every request within a few cycles.
`timescale 1ns/100ps
`default_nettype none
`include "lesl_defs.svh"

module testbench;
  logic clock = 1'b0, rst = 1'b1, instr_valid = 1'b0, init_we = 1'b0;
  logic init_flags_we = 1'b0, mem_ack, mem_req_r, mem_half_r, busy_r, done_r;
  logic fault_r, illegal_r, wb_valid_r, flag_n_r, flag_z_r, flag_c_r, flag_v_r;
  logic [15:0] instr = 16'h0000;
  logic [2:0]  init_idx = 3'h0, wb_idx_r, e_idx;
  logic [31:0] init_data = 32'h0, mem_addr_r, mem_rdata, wb_data_r, seed, e_dat, e_addr;
  logic [3:0]  init_flags = 4'h0, mf;
  logic [1:0]  lat = 2'h0;
  logic [31:0] m_reg [8];
  logic        e_wb, e_flt, e_ill, e_ld, e_half;
  int          err_total = 0, n_checks = 0, k;

  // Clock of 25 ns.
  always #12.5 clock = ~clock;

  lesl_exec u_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .init_we(init_we), .init_idx(init_idx), .init_data(init_data),
    .init_flags_we(init_flags_we), .init_flags(init_flags), .mem_req_r(mem_req_r),
    .mem_half_r(mem_half_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy_r(busy_r), .done_r(done_r), .fault_r(fault_r),
    .illegal_r(illegal_r), .wb_valid_r(wb_valid_r), .wb_idx_r(wb_idx_r),
    .wb_data_r(wb_data_r), .flag_n_r(flag_n_r), .flag_z_r(flag_z_r),
    .flag_c_r(flag_c_r), .flag_v_r(flag_v_r));

  lesl_mem_model u_mem (.clock(clock), .rst(rst), .mem_req_r(mem_req_r),
    .mem_addr_r(mem_addr_r), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Same memory content as the memory model holds.
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return (a * 32'h9E3779B1) ^ 32'h5A5A0F0F;
  endfunction : mem_word

  // Advances the random state with an xorshift step.
  function automatic void rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction : rnd

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict and stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Reference model: works out the outcome of one instruction and updates its state.
  task automatic model(input logic [15:0] i);
    logic [31:0] v, d;
    logic [32:0] s;
    logic [7:0]  amt;
    logic        sh;
    e_wb = 1'b1; e_flt = 1'b0; e_ill = 1'b0; e_ld = 1'b1; e_half = 1'b0; sh = 1'b0;
    e_idx = i[2:0];
    e_addr = m_reg[i[5:3]] + m_reg[i[8:6]];
    if (i[15:11] == `LESL_OP5_LDH_U_IMM) e_addr = m_reg[i[5:3]] + {26'h0, i[10:6], 1'b0};
    d = mem_word(e_addr);
    v = m_reg[i[5:3]];
    amt = {3'h0, i[10:6]};
    case (1'b1)
      i[15:9] == `LESL_OP7_LDB_U_REG: e_dat = {24'h0, d[7:0]};
      i[15:9] == `LESL_OP7_LDB_S_REG: e_dat = {{24{d[7]}}, d[7:0]};
      i[15:9] == `LESL_OP7_LDH_S_REG: {e_half, e_dat} = {1'b1, {16{d[15]}}, d[15:0]};
      i[15:9] == `LESL_OP7_LDH_U_REG || i[15:11] == `LESL_OP5_LDH_U_IMM:
        {e_half, e_dat} = {1'b1, 16'h0, d[15:0]};
      i[15:11] == `LESL_OP5_SHL_IMM: sh = 1'b1;
      i[15:6] == `LESL_OP10_SHL_REG: {sh, v, amt} = {1'b1, m_reg[i[2:0]], m_reg[i[5:3]][7:0]};
      default: {e_ill, e_wb, e_ld} = 3'b100;
    endcase
    if (sh) begin
      s = (amt == 8'h00) ? {mf[1], v} : ({1'b0, v} << amt);
      e_ld = 1'b0;
      e_dat = s[31:0];
      mf = {s[31], s[31:0] == 32'h0, s[32], mf[0]};
    end
    if (e_half && e_addr[0]) {e_flt, e_wb, e_ld} = 3'b100;
    if (e_wb) m_reg[e_idx] = e_dat;
  endtask : model

  // Preloads one register and the flags.
  task automatic pre(input logic [2:0] x, input logic [31:0] d, input logic [3:0] f);
    {init_we, init_idx, init_data, init_flags_we, init_flags} = {1'b1, x, d, 1'b1, f};
    @(posedge clock);
    @(negedge clock);
    {init_we, init_flags_we} = 2'b00;
    m_reg[x] = d;
    mf = f;
  endtask : pre

  // Issues one instruction, waits for it to finish and compares the outcome.
  task automatic run(input logic [15:0] i);
    int  w;
    logic seen;
    model(i);
    seen = 1'b0;
    rnd();
    lat = seed[1:0];
    {instr_valid, instr} = {1'b1, i};
    @(posedge clock);
    @(negedge clock);
    instr_valid = 1'b0;
    for (w = 0; w < 20 && done_r !== 1'b1; w++) begin
      if (mem_req_r === 1'b1 && !seen) begin
        seen = 1'b1;
        chk(mem_addr_r, e_addr, "address");
        chk(mem_half_r, e_half, "size");
        chk(busy_r, 1'b1, "busy");
      end
      @(negedge clock);
    end
    chk(seen, e_ld, "memory access");
    chk(busy_r, 1'b0, "idle");
    chk(done_r, 1'b1, "done");
    chk(wb_valid_r, e_wb, "write-back");
    chk(fault_r, e_flt, "fault");
    chk(illegal_r, e_ill, "illegal");
    if (e_wb) begin
      chk(wb_idx_r, e_idx, "target");
      chk(wb_data_r, e_dat, "data");
    end
    chk({flag_n_r, flag_z_r, flag_c_r, flag_v_r}, mf, "flags");
  endtask : run

  // Cuts a hang short.
  initial begin
    #500000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Reset, then directed boundaries, then random traffic.
  initial begin
    seed = 32'h70DF9AE5;
    mf = 4'h0;
    for (k = 0; k < 8; k++) m_reg[k] = 32'h0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    pre(3'h0, 32'h0, 4'h2);
    pre(3'h1, 32'h20, 4'h0);
    pre(3'h2, 32'h21, 4'h2);
    pre(3'h3, 32'h101, 4'h3);
    pre(3'h4, 32'h80000001, 4'h2);
    pre(3'h5, 32'hFFFFFF80, 4'h1);
    pre(3'h6, 32'h1, 4'h2);
    pre(3'h7, 32'h12345677, 4'h2);
    for (k = 0; k < 8; k++) run({`LESL_OP10_SHL_REG, 3'(k), 3'(7 - k)});
    run({`LESL_OP5_SHL_IMM, 5'h00, 3'h6, 3'h1});
    run({`LESL_OP5_SHL_IMM, 5'h1F, 3'h6, 3'h2});
    run(16'hFFFF);
    pre(3'h1, 32'h1001, 4'h0);
    pre(3'h2, 32'h0, 4'h0);
    run({`LESL_OP7_LDH_U_REG, 3'h2, 3'h1, 3'h3});
    run({`LESL_OP5_LDH_U_IMM, 5'h1F, 3'h2, 3'h0});
    $display("test directed done");
    for (k = 0; k < 400; k++) begin
      rnd();
      if (k % 4 == 0) pre(seed[2:0], {seed[31:8], seed[29] ? 8'h00 : seed[7:0]}, seed[11:8]);
      rnd();
      case (seed[18:16])
        3'h0: run({`LESL_OP7_LDB_U_REG, seed[8:0]});
        3'h1: run({`LESL_OP7_LDH_U_REG, seed[8:0]});
        3'h2: run({`LESL_OP7_LDB_S_REG, seed[8:0]});
        3'h3: run({`LESL_OP7_LDH_S_REG, seed[8:0]});
        3'h4: run({`LESL_OP5_LDH_U_IMM, seed[10:0]});
        3'h5: run({`LESL_OP5_SHL_IMM, seed[10:0]});
        3'h6: run({`LESL_OP10_SHL_REG, seed[5:0]});
        default: run(seed[15:0]);
      endcase
    end
    $display("test random done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
